// ### lock_chk_asserts.sv
// Checker for the ROM security lock.
`timescale 1ns/1ps
module lock_chk (
  input wire logic core_clk, rst_n, boot_busy, table_read_req, table_read_from_ext,
  input wire logic table_read_blocked, verify_req, verify_refused, access_select_eff,
  input wire logic lock_table_read, lock_verify, key_present,
  input wire logic [7:0] table_read_data, verify_data, table_rom_data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_ext_block: assert property (table_read_req && table_read_from_ext && lock_table_read
    |-> table_read_blocked) else $error("ext read");
  chk_block_zero: assert property (table_read_blocked |=> table_read_data == 8'h00)
    else $error("blocked data");
  chk_int_pass: assert property (table_read_req && !table_read_from_ext && !boot_busy
    |=> table_read_data == $past(table_rom_data)) else $error("int data");
  chk_ea_hold: assert property (lock_table_read && !boot_busy && !$past(boot_busy)
    |-> $stable(access_select_eff)) else $error("ea held");
  chk_verify_refuse: assert property (verify_req && lock_verify |-> verify_refused)
    else $error("verify");
  chk_refuse_zero: assert property (verify_refused |=> verify_data == 8'h00)
    else $error("refused data");
  chk_bit_two_dep: assert property (lock_verify |-> lock_table_read)
    else $error("bit two");
  chk_status_hold: assert property (!boot_busy && !$past(boot_busy)
    |-> $stable({lock_table_read, lock_verify, key_present})) else $error("status");
endmodule
bind rom_security_lock lock_chk u_chk (.*);

// ### rom_image_model.sv
// Model of the ROM image that answers the boot walk one cycle late.
`timescale 1ns/1ps
module rom_image_model (
  // Clock
  input wire logic core_clk,
  // Image contents
  input wire logic [7:0] key_fill,
  input wire logic [7:0] sec_fill,
  // Boot port
  input wire logic [15:0] boot_addr,
  output logic [7:0] boot_data
);
  always_ff @(posedge core_clk) begin
    boot_data <= (boot_addr == rom_lock_pkg::SECURITY_ADDR) ? sec_fill : key_fill;
  end
endmodule

// ### rom_lock_pkg.sv
// Package of constants for the ROM security-lock block.
package rom_lock_pkg;

  localparam int ADDR_W = 16;
  localparam logic [15:0] USER_END_ADDR = 16'h7fff;
  localparam logic [15:0] KEY_BASE_ADDR = 16'h8000;
  localparam logic [15:0] KEY_END_ADDR = 16'h803f;
  localparam logic [15:0] SECURITY_ADDR = 16'h8040;
  localparam int KEY_BYTES = 64;
  localparam logic [7:0] KEY_BLANK = 8'hff;
  localparam int SEC_BIT1_POS = 0;
  localparam int SEC_BIT2_POS = 1;
  localparam logic SEC_ENABLED = 1'b0;

  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10
  } lock_state_t;

endpackage

// ### rom_security_lock.sv
// ROM security lock: reset-time decode of the security byte and access gating.
//
// Overview of operation
// - Security bit one blocks external table reads.
// - Bit one latches access select at reset.
// - Security bit two refuses user-ROM verify.
// - Bit two acts only with bit one.
// - Security bits are active low.
// - 64 key bytes; FFH means no encryption.
// - Fixed layout of code, key, security byte.
// - Non-blank key encrypts verify data.
`timescale 1ns/1ps

module rom_security_lock #(
  parameter int ADDR_W = rom_lock_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Boot-time ROM read port
  output logic [ADDR_W-1:0] boot_addr,
  input wire logic [7:0] boot_data,
  output logic boot_busy,
  // External access select pin
  input wire logic external_access_select,
  output logic access_select_eff,
  // Table read request from the core
  input wire logic table_read_req,
  input wire logic table_read_from_ext,
  input wire logic [7:0] table_rom_data,
  output logic table_read_blocked,
  output logic [7:0] table_read_data,
  // Verify mode request
  input wire logic verify_req,
  input wire logic [7:0] verify_rom_data,
  input wire logic [5:0] verify_key_idx,
  output logic verify_refused,
  output logic [7:0] verify_data,
  // Decoded protection status
  output logic lock_table_read,
  output logic lock_verify,
  output logic key_present
);

  rom_lock_pkg::lock_state_t state_reg, state_next;
  logic [ADDR_W-1:0] addr_reg;
  logic sec1_reg, sec2_reg, key_reg;
  logic [7:0] key_mem [rom_lock_pkg::KEY_BYTES];
  logic [2:0] ea_sync_reg;
  logic ea_hold_reg;
  logic [7:0] tdata_reg, vdata_reg;

  // Both security bits share one decode, so polarity lives in a single place.
  function automatic logic sec_bit_on(input logic [7:0] b, input int pos);
    return b[pos] == rom_lock_pkg::SEC_ENABLED;
  endfunction

  // The ROM answers one cycle after the address, so each byte is sampled in ST_WAIT.
  wire logic in_key = (addr_reg >= ADDR_W'(rom_lock_pkg::KEY_BASE_ADDR))
                   && (addr_reg <= ADDR_W'(rom_lock_pkg::KEY_END_ADDR));
  wire logic at_sec = addr_reg == ADDR_W'(rom_lock_pkg::SECURITY_ADDR);
  wire logic [5:0] key_idx = 6'(addr_reg - ADDR_W'(rom_lock_pkg::KEY_BASE_ADDR));
  wire logic sample = state_reg == rom_lock_pkg::ST_WAIT;
  wire logic sec1_on = sec_bit_on(boot_data, rom_lock_pkg::SEC_BIT1_POS);
  wire logic sec2_on = sec_bit_on(boot_data, rom_lock_pkg::SEC_BIT2_POS);
  wire logic ea_stable = ea_sync_reg[1] == ea_sync_reg[2];
  wire logic running = state_reg == rom_lock_pkg::ST_RUN;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      rom_lock_pkg::ST_FETCH: state_next = rom_lock_pkg::ST_WAIT;
      rom_lock_pkg::ST_WAIT: state_next = at_sec ? rom_lock_pkg::ST_RUN
                                                 : rom_lock_pkg::ST_FETCH;
      rom_lock_pkg::ST_RUN: state_next = rom_lock_pkg::ST_RUN;
      default: state_next = rom_lock_pkg::ST_FETCH;
    endcase
  end

  // Walk the key bytes and then the security byte once after reset.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= rom_lock_pkg::ST_FETCH;
      addr_reg <= ADDR_W'(rom_lock_pkg::KEY_BASE_ADDR);
    end else begin
      state_reg <= state_next;
      if (sample && !at_sec) begin
        addr_reg <= addr_reg + 1'b1;
      end
    end
  end

  // Decoded controls change only during the boot walk and then hold until reset.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sec1_reg <= 1'b0;
      sec2_reg <= 1'b0;
      key_reg <= 1'b0;
    end else if (sample) begin
      if (at_sec) begin
        sec1_reg <= sec1_on;
        sec2_reg <= sec1_on && sec2_on;
      end else if (in_key && boot_data != rom_lock_pkg::KEY_BLANK) begin
        key_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sample && in_key) begin
      key_mem[key_idx] <= boot_data;
    end
  end

  // The pin is synchronised; the held copy is taken as the boot walk finishes.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ea_sync_reg <= 3'h0;
      ea_hold_reg <= 1'b0;
    end else begin
      ea_sync_reg <= {ea_sync_reg[1:0], external_access_select};
      if (!running && ea_stable) begin
        ea_hold_reg <= ea_sync_reg[2];
      end
    end
  end

  // With bit one set the held level wins, so later pin changes are ignored.
  assign access_select_eff = sec1_reg ? ea_hold_reg : ea_sync_reg[2];

  wire logic tblock = table_read_req && table_read_from_ext && (sec1_reg || !running);
  wire logic vrefuse = verify_req && (sec2_reg || !running);

  // Encryption is a per-byte XNOR with the key; a blank key leaves data plain.
  wire logic [7:0] venc = key_reg ? ~(verify_rom_data ^ key_mem[verify_key_idx])
                                  : verify_rom_data;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tdata_reg <= 8'h00;
      vdata_reg <= 8'h00;
    end else begin
      if (table_read_req) begin
        tdata_reg <= tblock ? 8'h00 : table_rom_data;
      end
      if (verify_req) begin
        vdata_reg <= vrefuse ? 8'h00 : venc;
      end
    end
  end

  assign boot_addr = addr_reg;
  assign boot_busy = !running;
  assign table_read_blocked = tblock;
  assign table_read_data = tdata_reg;
  assign verify_refused = vrefuse;
  assign verify_data = vdata_reg;
  assign lock_table_read = sec1_reg;
  assign lock_verify = sec2_reg;
  assign key_present = key_reg;

endmodule

// ### test_rom_security_lock.sv
// Testbench for the ROM security lock.
`timescale 1ns/1ps
module test_rom_security_lock;
  logic core_clk = 0, rst_n = 0, external_access_select = 1;
  logic table_read_req = 0, table_read_from_ext = 0, verify_req = 0;
  logic [7:0] table_rom_data = 8'h5a, verify_rom_data = 8'h5a, key_fill, sec_fill;
  logic [5:0] verify_key_idx = 6'h00;
  logic [15:0] boot_addr;
  logic [7:0] boot_data, table_read_data, verify_data;
  logic boot_busy, access_select_eff, table_read_blocked, verify_refused;
  logic lock_table_read, lock_verify, key_present;
  int miscompares = 0, cmp_count = 0;
  always #5 core_clk = ~core_clk;
  rom_security_lock dut (.*);
  rom_image_model image (.core_clk, .key_fill, .sec_fill, .boot_addr, .boot_data);
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic run_cfg(input logic [7:0] s, input logic [7:0] k);
    logic l1, l2;
    l1 = !s[0];
    l2 = l1 && !s[1];
    @(posedge core_clk) begin sec_fill <= s; key_fill <= k; rst_n <= 0; end
    @(posedge core_clk) rst_n <= 1;
    #1 chk("busy_boot", 8'h01, boot_busy);
    chk("addr_start", 8'h00, boot_addr[7:0]);
    repeat (132) @(posedge core_clk);
    #1 chk("busy", 8'h00, boot_busy);
    chk("addr_hi", 8'h80, boot_addr[15:8]);
    chk("addr_lo", 8'h40, boot_addr[7:0]);
    chk("lock_table", l1, lock_table_read);
    chk("lock_verify", l2, lock_verify);
    chk("key", k != 8'hff, key_present);
    for (int m = 0; m < 3; m++) begin
      @(posedge core_clk) begin
        table_read_req <= m < 2; table_read_from_ext <= m[0]; verify_req <= m == 2;
      end
      #1 chk("blocked", m == 1 && l1, table_read_blocked);
      chk("refused", m == 2 && l2, verify_refused);
      @(posedge core_clk) begin table_read_req <= 0; verify_req <= 0; end
      if (m < 2) #1 chk("read", (m == 1 && l1) ? 8'h00 : 8'h5a, table_read_data);
      else #1 chk("verify", l2 ? 8'h00 : ~(8'h5a ^ k), verify_data);
    end
    @(posedge core_clk) external_access_select <= 0;
    repeat (5) @(posedge core_clk);
    #1 chk("ea", l1, access_select_eff);
    @(posedge core_clk) external_access_select <= 1;
    $display("Test done sec %h key %h", s, k);
  endtask
  task automatic test_open();
    run_cfg(8'hff, 8'hff);
  endtask
  task automatic test_lock_one();
    run_cfg(8'hfe, 8'hff);
  endtask
  task automatic test_lock_both();
    run_cfg(8'hfc, 8'h3c);
  endtask
  task automatic test_bit_two_alone();
    run_cfg(8'hfd, 8'h3c);
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    test_open();
    test_lock_one();
    test_lock_both();
    test_bit_two_alone();
    close_out();
  end
  initial begin
    #50000;
    miscompares++;
    close_out();
  end
endmodule
